/* File: dihs_top.sv */
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module dihs_top #(
    parameter int NPORT = dihs_pkg::NUM_PORTS
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dihs_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NPORT-1:0] hsync_in,
    input wire logic [NPORT-1:0] de_in,
    output logic [NPORT*dihs_pkg::TIMING_W-1:0] sync_width_out,
    output logic [NPORT*dihs_pkg::TIMING_W-1:0] back_porch_out
);
    localparam int W = dihs_pkg::TIMING_W;
    localparam int PW = (NPORT > 1) ? $clog2(NPORT) : 1;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [NPORT-1:0][7:0] ctrl_high;
        logic [NPORT-1:0][7:0] sync_low;
        logic [NPORT-1:0][7:0] back_low;
        logic [PW-1:0] port_sel;
        logic rd_done;
        logic [31:0] rdata;
    } dihs_state_type;
    dihs_state_type s_r, s_nxt;

    function automatic logic hit(input logic [dihs_pkg::ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a[dihs_pkg::ADDR_W-1:2] == (dihs_pkg::ADDR_W-2)'(off)) && (a[1:0] == 2'b00);
    endfunction : hit

    logic [NPORT-1:0][W-1:0] meas_sync, meas_back;
    logic [NPORT-1:0][W-1:0] reg_sync, reg_back;
    logic access, wr, mapped;
    logic [7:0] rd_byte;
    logic [PW-1:0] ps;

    assign access = psel && penable && clk_en;
    assign wr = access && pwrite && pstrb[0];
    assign ps = s_r.port_sel;
    // printed offsets are register indices; byte address is four times the index
    assign mapped = hit(paddr, dihs_pkg::REG_CTRL_HIGH) || hit(paddr, dihs_pkg::REG_SYNC_LOW)
        || hit(paddr, dihs_pkg::REG_BACK_LOW) || hit(paddr, dihs_pkg::REG_PORT_SEL)
        || hit(paddr, dihs_pkg::REG_MEASURED);

    // ----------------------------------------
    // register access
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        rd_byte = 8'h00;
        if (hit(paddr, dihs_pkg::REG_CTRL_HIGH)) begin
            rd_byte = s_r.ctrl_high[ps] & dihs_pkg::CTRL_WRITE_MASK;
        end else if (hit(paddr, dihs_pkg::REG_SYNC_LOW)) begin
            rd_byte = s_r.sync_low[ps];
        end else if (hit(paddr, dihs_pkg::REG_BACK_LOW)) begin
            rd_byte = s_r.back_low[ps];
        end else if (hit(paddr, dihs_pkg::REG_PORT_SEL)) begin
            rd_byte = 8'(s_r.port_sel);
        end else if (hit(paddr, dihs_pkg::REG_MEASURED)) begin
            // status: low byte of measured sync width of selected port
            rd_byte = meas_sync[ps][7:0];
        end
        // one wait state on reads keeps prdata a flop yet valid when pready rises
        if (access && !pwrite) begin
            if (!s_r.rd_done) begin
                s_nxt.rdata = {24'h000000, rd_byte};
                s_nxt.rd_done = 1'b1;
            end else begin
                s_nxt.rd_done = 1'b0;
            end
        end
        if (wr) begin
            if (hit(paddr, dihs_pkg::REG_CTRL_HIGH)) begin
                s_nxt.ctrl_high[ps] = pwdata[7:0] & dihs_pkg::CTRL_WRITE_MASK;
            end else if (hit(paddr, dihs_pkg::REG_SYNC_LOW)) begin
                s_nxt.sync_low[ps] = pwdata[7:0];
            end else if (hit(paddr, dihs_pkg::REG_BACK_LOW)) begin
                s_nxt.back_low[ps] = pwdata[7:0];
            end else if (hit(paddr, dihs_pkg::REG_PORT_SEL)) begin
                s_nxt.port_sel = (pwdata[7:0] < 8'(NPORT - 1)) ? PW'(pwdata[7:0])
                    : PW'(NPORT - 1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    // writes take no wait state, reads one; unmapped addresses answer with an error
    assign pready = !(psel && penable) || (clk_en && (pwrite || s_r.rd_done));
    assign pslverr = psel && penable && !mapped;
    assign prdata = s_r.rdata;

    // ----------------------------------------
    // per-port measure and select
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : g_port
            // ten-bit override values assembled from high and low fields
            assign reg_sync[g] = {s_r.ctrl_high[g][dihs_pkg::SYNC_HI_LSB +: 2],
                s_r.sync_low[g]};
            assign reg_back[g] = {s_r.ctrl_high[g][dihs_pkg::BACK_HI_LSB +: 2],
                s_r.back_low[g]};
            dihs_hmeasure #(.W(W)) u_meas (
                .core_clk(core_clk),
                .arst_n(arst_n),
                .clk_en(clk_en),
                .hsync_in(hsync_in[g]),
                .de_in(de_in[g]),
                .sync_width(meas_sync[g]),
                .back_porch(meas_back[g])
            );
            dihs_regen #(.W(W)) u_sel (
                .core_clk(core_clk),
                .arst_n(arst_n),
                .clk_en(clk_en),
                .sync_en(s_r.ctrl_high[g][dihs_pkg::SYNC_EN_BIT]),
                .sync_ov(reg_sync[g]),
                .sync_meas(meas_sync[g]),
                .back_en(s_r.ctrl_high[g][dihs_pkg::BACK_EN_BIT]),
                .back_ov(reg_back[g]),
                .back_meas(meas_back[g]),
                .sync_width(sync_width_out[g*W +: W]),
                .back_porch(back_porch_out[g*W +: W])
            );
        end
    endgenerate
endmodule : dihs_top

/* File: dihs_pkg.sv */
package dihs_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL_HIGH = 8'h6A;
    localparam logic [7:0] REG_SYNC_LOW = 8'h6B;
    localparam logic [7:0] REG_BACK_LOW = 8'h6C;
    localparam logic [7:0] REG_PORT_SEL = 8'h70;
    localparam logic [7:0] REG_MEASURED = 8'h71;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    // ----------------------------------------
    // fields of the first control register, then timing width, port count, address width and bus phase type
    // ----------------------------------------
    localparam int BACK_EN_BIT = 7;
    localparam int BACK_HI_LSB = 4;
    localparam int SYNC_EN_BIT = 3;
    localparam int SYNC_HI_LSB = 0;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hBB;
    localparam int TIMING_W = 10;
    localparam int NUM_PORTS = 2;
    localparam int ADDR_W = 12;
    typedef enum logic [1:0] {DIHS_IDLE, DIHS_ACCESS} dihs_phase_type;
endpackage : dihs_pkg

/* File: dihs_hmeasure.sv */
`timescale 1ns/1ps
module dihs_hmeasure #(
    parameter int W = 10
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic hsync_in,
    input wire logic de_in,
    output logic [W-1:0] sync_width,
    output logic [W-1:0] back_porch
);
    typedef struct packed {
        logic hs_d;
        logic de_d;
        logic in_bp;
        logic [W-1:0] cnt;
        logic [W-1:0] sync_width;
        logic [W-1:0] back_porch;
    } dihs_meas_type;
    dihs_meas_type s_r, s_nxt;
    always_comb begin
        s_nxt = s_r;
        s_nxt.hs_d = hsync_in;
        s_nxt.de_d = de_in;
        if (hsync_in && !s_r.hs_d) begin
            s_nxt.cnt = W'(1);
            s_nxt.in_bp = 1'b0;
        end else if (hsync_in) begin
            s_nxt.cnt = s_r.cnt + W'(1);
        end else if (s_r.hs_d) begin
            // sync just ended: latch width, start back porch count
            s_nxt.sync_width = s_r.cnt;
            s_nxt.cnt = W'(1);
            s_nxt.in_bp = 1'b1;
        end else if (s_r.in_bp && de_in) begin
            s_nxt.back_porch = s_r.cnt;
            s_nxt.in_bp = 1'b0;
        end else if (s_r.in_bp) begin
            s_nxt.cnt = s_r.cnt + W'(1);
        end
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end
    assign sync_width = s_r.sync_width;
    assign back_porch = s_r.back_porch;
endmodule : dihs_hmeasure

/* File: dihs_regen.sv */
`timescale 1ns/1ps
module dihs_regen #(
    parameter int W = 10
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic sync_en,
    input wire logic [W-1:0] sync_ov,
    input wire logic [W-1:0] sync_meas,
    input wire logic back_en,
    input wire logic [W-1:0] back_ov,
    input wire logic [W-1:0] back_meas,
    output logic [W-1:0] sync_width,
    output logic [W-1:0] back_porch
);
    typedef struct packed {
        logic [W-1:0] sync_width;
        logic [W-1:0] back_porch;
    } dihs_sel_type;
    dihs_sel_type s_r, s_nxt;
    always_comb begin
        s_nxt.sync_width = sync_en ? sync_ov : sync_meas;
        s_nxt.back_porch = back_en ? back_ov : back_meas;
    end
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end
    assign sync_width = s_r.sync_width;
    assign back_porch = s_r.back_porch;
endmodule : dihs_regen

/* File: dihs_monitor.sv */
`timescale 1ns/1ps
module dihs_monitor #(
    parameter int NPORT = 2
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ----------------------------------------
    // bus relations
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic acc;
    logic mapped;
    logic [11:0] wa_r;
    logic [7:0] wd_r;
    assign acc = psel && penable && clk_en;
    assign mapped = paddr inside {12'h1A8, 12'h1AC, 12'h1B0, 12'h1C0, 12'h1C4};
    // last accepted write, so readback checks need no fixed spacing between accesses
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wa_r <= 12'h000;
            wd_r <= 8'h00;
        end else if (acc && pwrite && pstrb[0]) begin
            wa_r <= paddr;
            wd_r <= pwdata[7:0];
        end
    end
    sequence rd_s(logic [11:0] a);
        acc && !pwrite && paddr == a;
    endsequence
    write_ready_a: assert property (acc && pwrite |-> pready) else $error("write waited");
    read_wait_a: assert property (acc && !pwrite && !pready ##1 clk_en |-> pready)
        else $error("read wait too long");
    bus_err_a: assert property (pslverr == (psel && penable && !mapped))
        else $error("pslverr wrong");
    upper_zero_a: assert property (acc && !pwrite |=> prdata[31:8] == 24'h0)
        else $error("read upper bits set");
    unmap_read_a: assert property (acc && !pwrite && !mapped |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    rsvd_zero_a: assert property (rd_s(12'h1A8) |=> !prdata[6] && !prdata[2])
        else $error("reserved bit set");
    ctrl_back_a: assert property (rd_s(12'h1A8) ##0 wa_r == 12'h1A8 |=>
        prdata[7:0] == (wd_r & 8'hBB)) else $error("control readback wrong");
    sync_low_a: assert property (rd_s(12'h1AC) ##0 wa_r == 12'h1AC |=>
        prdata[7:0] == wd_r) else $error("sync low readback wrong");
    back_low_a: assert property (rd_s(12'h1B0) ##0 wa_r == 12'h1B0 |=>
        prdata[7:0] == wd_r) else $error("porch low readback wrong");
    rd_hold_a: assert property (!(acc && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
endmodule : dihs_monitor

bind dihs_top dihs_monitor #(.NPORT(NPORT)) i_dihs_monitor (.core_clk(core_clk),
    .arst_n(arst_n), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

/* File: dihs_video_src.sv */
`timescale 1ns/1ps
module dihs_video_src #(
    parameter int SYNC = 4,
    parameter int BACK = 6
) (
    input wire logic core_clk,
    input wire logic arst_n,
    output logic hsync,
    output logic de
);
    // free-running lines: sync, back porch, 12 active, 4 front porch
    int pos;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pos <= 0;
        end else begin
            pos <= (pos == SYNC + BACK + 15) ? 0 : pos + 1;
        end
    end
    assign hsync = arst_n && pos < SYNC;
    assign de = pos >= SYNC + BACK && pos < SYNC + BACK + 12;
endmodule : dihs_video_src

/* File: tb_dual_image_hsync_override.sv */
`timescale 1ns/1ps
module tb_dual_image_hsync_override;
    logic core_clk, arst_n, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [1:0] hsync_in, de_in;
    logic [19:0] sync_width_out, back_porch_out;
    int n_errors = 0;
    int cmp_count = 0;
    logic last_err;
    dihs_top #(.NPORT(2)) i_dihs_top (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hsync_in(hsync_in), .de_in(de_in), .sync_width_out(sync_width_out),
        .back_porch_out(back_porch_out));
    dihs_video_src #(.SYNC(4), .BACK(6)) i_dihs_video_src0 (.core_clk(core_clk),
        .arst_n(arst_n), .hsync(hsync_in[0]), .de(de_in[0]));
    dihs_video_src #(.SYNC(5), .BACK(7)) i_dihs_video_src1 (.core_clk(core_clk),
        .arst_n(arst_n), .hsync(hsync_in[1]), .de(de_in[1]));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // read data and error are taken at the edge where pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr
    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 8'h00, r);
        chk(name, exp, r);
    endtask : rdchk
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (3000) @(posedge core_clk);
        n_errors++;
        end_of_test();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        rdchk("ctrl reset", 12'h1A8, 32'h00000000);
        rdchk("sync low reset", 12'h1AC, 32'h00000000);
        rdchk("back low reset", 12'h1B0, 32'h00000000);
        $display("test reset done");
        repeat (120) @(posedge core_clk);
        chk("sync p0", 32'h4, 32'(sync_width_out[9:0]));
        chk("back p0", 32'h6, 32'(back_porch_out[9:0]));
        chk("sync p1", 32'h5, 32'(sync_width_out[19:10]));
        chk("back p1", 32'h7, 32'(back_porch_out[19:10]));
        $display("test measured done");
        wr(12'h1A8, 8'hFF);
        rdchk("ctrl mask", 12'h1A8, 32'h000000BB);
        chk("mapped err", 32'h0, 32'(last_err));
        wr(12'h1AC, 8'h34);
        // twice a 2D porch of 0x189
        wr(12'h1B0, 8'h12);
        repeat (2) @(posedge core_clk);
        chk("sync ov p0", 32'h334, 32'(sync_width_out[9:0]));
        chk("back ov p0", 32'h312, 32'(back_porch_out[9:0]));
        chk("sync p1 kept", 32'h5, 32'(sync_width_out[19:10]));
        $display("test override port 0 done");
        wr(12'h1C0, 8'h01);
        rdchk("ctrl p1", 12'h1A8, 32'h00000000);
        wr(12'h1A8, 8'h08);
        wr(12'h1AC, 8'hAB);
        repeat (2) @(posedge core_clk);
        chk("sync ov p1", 32'h0AB, 32'(sync_width_out[19:10]));
        chk("back p1 meas", 32'h7, 32'(back_porch_out[19:10]));
        chk("sync p0 kept", 32'h334, 32'(sync_width_out[9:0]));
        $display("test override port 1 done");
        wr(12'h1D0, 8'hFF);
        rdchk("unmapped", 12'h1D0, 32'h00000000);
        chk("unmapped err", 32'h1, 32'(last_err));
        $display("test unmapped done");
        end_of_test();
    end
endmodule : tb_dual_image_hsync_override
